// *** shared/ppc_map.svh ***
// Offsets, field positions and reset values of the parallel port
// configuration bank. Assumes includers use the bare file name.
`ifndef PPC_MAP_SVH
`define PPC_MAP_SVH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define PPC_OFF_ACTIVATE 8'h30
`define PPC_OFF_BASE_HI  8'h60
`define PPC_OFF_BASE_LO  8'h61
`define PPC_OFF_IRQ      8'h70
`define PPC_OFF_DMA      8'h74
`define PPC_OFF_MODE     8'hf0

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define PPC_RST_ACTIVATE 8'h01
`define PPC_RST_BASE_HI  8'h03
`define PPC_RST_BASE_LO  8'h78
`define PPC_RST_IRQ      8'h07
`define PPC_RST_DMA      8'h04
`define PPC_RST_MODE     8'h3f

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define PPC_ACT_BIT      0
`define PPC_IRQ_MSB      3
`define PPC_DMA_MSB      2
`define PPC_DMA_OFF_BIT  2
`define PPC_MODE_MSB     2
`define PPC_FIFO_LSB     3
`define PPC_FIFO_MSB     6

// ----------------------------------------------------------------
// Base address window and mode field codes
// ----------------------------------------------------------------
`define PPC_BASE_MIN     16'h0100
`define PPC_BASE_MAX4    16'h0ffc
`define PPC_BASE_MAX8    16'h0ff8
`define PPC_MC_SPP       3'h0
`define PPC_MC_EPP19     3'h1
`define PPC_MC_ECP       3'h2
`define PPC_MC_ECP_EPP19 3'h3
`define PPC_MC_PRINTER   3'h4
`define PPC_MC_EPP17     3'h5
`define PPC_MC_RSVD      3'h6
`define PPC_MC_ECP_EPP17 3'h7

`endif

// *** shared/ppc_pkg.sv ***
// Types of the parallel port configuration bank.
// Assumes nothing beyond a SystemVerilog compiler.
package ppc_pkg;

	// ------------------------------------------------------------
	// Decoded operating mode, one-hot
	// ------------------------------------------------------------
	typedef enum logic [8:0] {
		PPC_MD_SPP       = 9'h001,
		PPC_MD_EPP19     = 9'h002,
		PPC_MD_ECP       = 9'h004,
		PPC_MD_ECP_EPP19 = 9'h008,
		PPC_MD_PRINTER   = 9'h010,
		PPC_MD_EPP17     = 9'h020,
		PPC_MD_RSVD      = 9'h040,
		PPC_MD_ECP_EPP17 = 9'h080,
		PPC_MD_EXTERN    = 9'h100
	} ppc_mode_t;

	// ------------------------------------------------------------
	// Whole state of the bank
	// ------------------------------------------------------------
	typedef struct packed {
		logic       act;
		logic [7:0] base_hi;
		logic [7:0] base_lo;
		logic [3:0] irq;
		logic [2:0] dma;
		logic [3:0] fifo;
		logic [2:0] mode;
		logic [7:0] rdata;
		logic       four_ok;
		logic       eight_ok;
		ppc_mode_t  mode_dec;
	} ppc_state_t;

endpackage

// *** src/ppc_base_check.sv ***
// Classifies the port base address by alignment and window.
// Assumes a stable registered base on its input.
`timescale 1ns/1ps
`default_nettype none
`include "ppc_map.svh"

module ppc_base_check (
	input  wire logic [15:0] base_i,
	output logic             four_ok_o,
	output logic             eight_ok_o
);

	// ------------------------------------------------------------
	// Window checks
	// ------------------------------------------------------------
	// Four-byte window allows every mode but the enhanced protocol
	assign four_ok_o  = (base_i[1:0] == 2'h0) &&
	                    (base_i >= `PPC_BASE_MIN) &&
	                    (base_i <= `PPC_BASE_MAX4);
	// Eight-byte window allows all modes
	assign eight_ok_o = (base_i[2:0] == 3'h0) &&
	                    (base_i >= `PPC_BASE_MIN) &&
	                    (base_i <= `PPC_BASE_MAX8);

endmodule
`default_nettype wire

// *** src/ppc_mode_decode.sv ***
// Decodes the three-bit port mode field into a one-hot mode.
// Assumes the override and alignment inputs come from flip-flops.
`timescale 1ns/1ps
`default_nettype none
`include "ppc_map.svh"

module ppc_mode_decode (
	input  wire logic [2:0]        field_i,
	input  wire logic              override_i,
	input  wire logic              eight_ok_i,
	output var ppc_pkg::ppc_mode_t mode_o
);

	// ------------------------------------------------------------
	// Field decode
	// ------------------------------------------------------------
	// Enhanced protocol drops out without eight-byte alignment
	always_comb begin
		mode_o = ppc_pkg::PPC_MD_SPP;
		if (override_i) begin
			mode_o = ppc_pkg::PPC_MD_EXTERN;
		end else begin
			case (field_i)
				`PPC_MC_SPP:       mode_o = ppc_pkg::PPC_MD_SPP;
				`PPC_MC_EPP19:     mode_o = eight_ok_i ? ppc_pkg::PPC_MD_EPP19
				                                       : ppc_pkg::PPC_MD_SPP;
				`PPC_MC_ECP:       mode_o = ppc_pkg::PPC_MD_ECP;
				`PPC_MC_ECP_EPP19: mode_o = eight_ok_i ? ppc_pkg::PPC_MD_ECP_EPP19
				                                       : ppc_pkg::PPC_MD_ECP;
				`PPC_MC_PRINTER:   mode_o = ppc_pkg::PPC_MD_PRINTER;
				`PPC_MC_EPP17:     mode_o = eight_ok_i ? ppc_pkg::PPC_MD_EPP17
				                                       : ppc_pkg::PPC_MD_SPP;
				`PPC_MC_RSVD:      mode_o = ppc_pkg::PPC_MD_RSVD;
				`PPC_MC_ECP_EPP17: mode_o = eight_ok_i ? ppc_pkg::PPC_MD_ECP_EPP17
				                                       : ppc_pkg::PPC_MD_ECP;
				default:           mode_o = ppc_pkg::PPC_MD_SPP;
			endcase
		end
	end

endmodule
`default_nettype wire

// *** src/ppc_bank.sv ***
// Configuration register bank of the printer port unit.
// Assumes a single clock, synchronous inputs and a plain
// address/strobe register port that never waits.
//
// Contract
// - Bit 0 of the activation register turns the port on when 1 and off when 0.
// - Two byte registers form the base; a four-byte aligned base denies the enhanced protocol.
// - An eight-byte aligned base in its window allows every mode, enhanced protocol included.
// - The low four bits of the interrupt select pick the host interrupt line.
// - DMA field codes 0 to 3 pick channels 0 to 3 and a set top bit turns requests off.
// - The mode field governs only while the global mode override is 0.
// - Mode codes 0, 1, 5, 4 and 6 are standard, 1.9 plus standard, 1.7 plus standard, printer, reserved.
// - Mode codes 2, 3 and 7 are extended alone, with enhanced 1.9, and with enhanced 1.7.
//
// Implementation choice: the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
`include "ppc_map.svh"

module ppc_bank #(
	parameter int ADDR_W = 8,
	parameter int DATA_W = 8
) (
	input  wire logic              clk_i,
	input  wire logic              rst_n_i,
	input  wire logic [ADDR_W-1:0] addr_i,
	input  wire logic [DATA_W-1:0] wdata_i,
	input  wire logic              wr_i,
	input  wire logic              rd_i,
	input  wire logic              global_port_mode_override_i,
	output logic      [DATA_W-1:0] rdata_o,
	output logic                   dev_active_o,
	output logic      [15:0]       base_addr_o,
	output logic                   base_valid_o,
	output logic                   epp_allowed_o,
	output logic      [3:0]        irq_sel_o,
	output logic                   dma_req_en_o,
	output logic      [1:0]        dma_chan_o,
	output logic      [3:0]        fifo_thresh_o,
	output var ppc_pkg::ppc_mode_t mode_o,
	output logic                   mode_from_field_o,
	output logic                   epp_active_o,
	output logic                   ecp_active_o
);

	// ------------------------------------------------------------
	// Elaboration check
	// ------------------------------------------------------------
	// Register map and fields are byte wide by construction
	generate
		if (ADDR_W != 8 || DATA_W != 8) begin : g_bad_width
			$error("ppc_bank supports only 8-bit address and data");
		end
	endgenerate

	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	ppc_pkg::ppc_state_t st_r;
	ppc_pkg::ppc_state_t st_nxt;
	logic                four_ok;
	logic                eight_ok;
	ppc_pkg::ppc_mode_t  mode_dec;

	// Select lines for each register, shared by write and read
	localparam int N_REG = 6;
	localparam int S_ACT = 0;
	localparam int S_BHI = 1;
	localparam int S_BLO = 2;
	localparam int S_IRQ = 3;
	localparam int S_DMA = 4;
	localparam int S_MOD = 5;

	// ------------------------------------------------------------
	// Address decode
	// ------------------------------------------------------------
	// One-hot select; all zero for an unmapped offset
	function automatic logic [N_REG-1:0] reg_sel(input logic [7:0] a);
		logic [N_REG-1:0] s;
		s = '0;
		case (a)
			`PPC_OFF_ACTIVATE: s[S_ACT] = 1'b1;
			`PPC_OFF_BASE_HI:  s[S_BHI] = 1'b1;
			`PPC_OFF_BASE_LO:  s[S_BLO] = 1'b1;
			`PPC_OFF_IRQ:      s[S_IRQ] = 1'b1;
			`PPC_OFF_DMA:      s[S_DMA] = 1'b1;
			`PPC_OFF_MODE:     s[S_MOD] = 1'b1;
			default:           s = '0;
		endcase
		return s;
	endfunction

	logic [N_REG-1:0] sel;
	assign sel = reg_sel(addr_i);

	// ------------------------------------------------------------
	// Readback image
	// ------------------------------------------------------------
	// Reserved bits are not stored, so they read zero
	logic [7:0] rd_val;
	always_comb begin
		rd_val = 8'h00;
		case (1'b1)
			sel[S_ACT]: rd_val = {7'h00, st_r.act};
			sel[S_BHI]: rd_val = st_r.base_hi;
			sel[S_BLO]: rd_val = st_r.base_lo;
			sel[S_IRQ]: rd_val = {4'h0, st_r.irq};
			sel[S_DMA]: rd_val = {5'h00, st_r.dma};
			sel[S_MOD]: rd_val = {1'b0, st_r.fifo, st_r.mode};
			default:    rd_val = 8'h00;
		endcase
	end

	// ------------------------------------------------------------
	// Derived checks on the held settings
	// ------------------------------------------------------------
	// Fed from flip-flops to keep the decode out of the write path
	ppc_base_check u_base (
		.base_i     ({st_r.base_hi, st_r.base_lo}),
		.four_ok_o  (four_ok),
		.eight_ok_o (eight_ok)
	);

	ppc_mode_decode u_mode (
		.field_i    (st_r.mode),
		.override_i (global_port_mode_override_i),
		.eight_ok_i (eight_ok),
		.mode_o     (mode_dec)
	);

	// ------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------
	// Writes keep only defined bits; reads present data one cycle
	always_comb begin
		st_nxt       = st_r;
		st_nxt.rdata = 8'h00;
		if (wr_i) begin
			if (sel[S_ACT]) begin
				st_nxt.act = wdata_i[`PPC_ACT_BIT];
			end
			if (sel[S_BHI]) begin
				st_nxt.base_hi = wdata_i;
			end
			if (sel[S_BLO]) begin
				st_nxt.base_lo = wdata_i;
			end
			if (sel[S_IRQ]) begin
				st_nxt.irq = wdata_i[`PPC_IRQ_MSB:0];
			end
			if (sel[S_DMA]) begin
				st_nxt.dma = wdata_i[`PPC_DMA_MSB:0];
			end
			if (sel[S_MOD]) begin
				st_nxt.mode = wdata_i[`PPC_MODE_MSB:0];
				st_nxt.fifo = wdata_i[`PPC_FIFO_MSB:`PPC_FIFO_LSB];
			end
		end
		if (rd_i) begin
			st_nxt.rdata = rd_val;
		end
		st_nxt.four_ok  = four_ok;
		st_nxt.eight_ok = eight_ok;
		st_nxt.mode_dec = mode_dec;
	end

	// ------------------------------------------------------------
	// State register
	// ------------------------------------------------------------
	// Reset values match the documented defaults
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			st_r.act      <= 1'(`PPC_RST_ACTIVATE);
			st_r.base_hi  <= `PPC_RST_BASE_HI;
			st_r.base_lo  <= `PPC_RST_BASE_LO;
			st_r.irq      <= 4'(`PPC_RST_IRQ);
			st_r.dma      <= 3'(`PPC_RST_DMA);
			st_r.fifo     <= 4'(`PPC_RST_MODE >> `PPC_FIFO_LSB);
			st_r.mode     <= 3'(`PPC_RST_MODE);
			st_r.rdata    <= 8'h00;
			st_r.four_ok  <= 1'b0;
			st_r.eight_ok <= 1'b0;
			st_r.mode_dec <= ppc_pkg::PPC_MD_SPP;
		end else begin
			st_r <= st_nxt;
		end
	end

	// ------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------
	assign rdata_o           = st_r.rdata;
	assign dev_active_o      = st_r.act;
	assign base_addr_o       = {st_r.base_hi, st_r.base_lo};
	assign base_valid_o      = st_r.four_ok;
	assign epp_allowed_o     = st_r.eight_ok;
	assign irq_sel_o         = st_r.irq;
	assign dma_req_en_o      = ~st_r.dma[`PPC_DMA_OFF_BIT];
	assign dma_chan_o        = st_r.dma[1:0];
	assign fifo_thresh_o     = st_r.fifo;
	assign mode_o            = st_r.mode_dec;
	assign mode_from_field_o = (st_r.mode_dec != ppc_pkg::PPC_MD_EXTERN);

	// Enhanced and extended flags, for the port datapath
	assign epp_active_o = (st_r.mode_dec == ppc_pkg::PPC_MD_EPP19) ||
	                      (st_r.mode_dec == ppc_pkg::PPC_MD_EPP17) ||
	                      (st_r.mode_dec == ppc_pkg::PPC_MD_ECP_EPP19) ||
	                      (st_r.mode_dec == ppc_pkg::PPC_MD_ECP_EPP17);
	assign ecp_active_o = (st_r.mode_dec == ppc_pkg::PPC_MD_ECP) ||
	                      (st_r.mode_dec == ppc_pkg::PPC_MD_ECP_EPP19) ||
	                      (st_r.mode_dec == ppc_pkg::PPC_MD_ECP_EPP17);

	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (!rst_n_i);

	// Activation bit lands on the next edge
	a_activate_write: assert property (
		wr_i && addr_i == `PPC_OFF_ACTIVATE |=> dev_active_o == $past(wdata_i[0])
	) else $error("activation bit not taken from write");

	// Low base byte lands in the low half of the base
	a_base_low_pair: assert property (
		wr_i && addr_i == `PPC_OFF_BASE_LO |=> base_addr_o[7:0] == $past(wdata_i)
	) else $error("low base byte not stored");

	// Enhanced protocol never active without eight-byte alignment
	a_four_byte_epp: assert property (
		!epp_allowed_o |-> !epp_active_o
	) else $error("enhanced protocol active on four-byte base");

	// Alignment flag follows the base held one cycle earlier
	a_eight_byte_window: assert property (
		epp_allowed_o |-> $past(base_addr_o[2:0]) == 3'h0 &&
		                 $past(base_addr_o) >= `PPC_BASE_MIN &&
		                 $past(base_addr_o) <= `PPC_BASE_MAX8
	) else $error("eight-byte flag outside its window");

	// Interrupt select keeps the low nibble
	a_irq_low_bits: assert property (
		wr_i && addr_i == `PPC_OFF_IRQ |=> irq_sel_o == $past(wdata_i[3:0])
	) else $error("interrupt select not stored");

	// Top DMA bit disables requests until the next DMA write
	a_dma_top_off: assert property (
		wr_i && addr_i == `PPC_OFF_DMA && wdata_i[2]
		|=> !dma_req_en_o ##1 (!dma_req_en_o || $past(wr_i && addr_i == `PPC_OFF_DMA))
	) else $error("DMA requests not disabled");

	// Codes 0 to 3 select the matching channel
	a_dma_chan_map: assert property (
		wr_i && addr_i == `PPC_OFF_DMA && !wdata_i[2]
		|=> dma_req_en_o && dma_chan_o == $past(wdata_i[1:0])
	) else $error("DMA channel mismatch");

	// Override takes the mode away from the field
	a_override_mask: assert property (
		$past(rst_n_i) && $past(global_port_mode_override_i)
		|-> mode_o == ppc_pkg::PPC_MD_EXTERN && !mode_from_field_o
	) else $error("mode field governs under override");

	// Printer code decodes to printer mode
	a_printer_code: assert property (
		!$past(global_port_mode_override_i) && $past(st_r.mode) == 3'h4
		|-> mode_o == ppc_pkg::PPC_MD_PRINTER
	) else $error("printer code misdecoded");

	// Code 3 with alignment is extended plus enhanced 1.9
	a_ecp_epp_code: assert property (
		!$past(global_port_mode_override_i) && $past(st_r.mode) == 3'h3 && epp_allowed_o
		|-> mode_o == ppc_pkg::PPC_MD_ECP_EPP19 && ecp_active_o && epp_active_o
	) else $error("extended plus enhanced code misdecoded");

	// Reserved activation bits read as zero
	a_reserved_zero: assert property (
		rd_i && addr_i == `PPC_OFF_ACTIVATE |=> rdata_o[7:1] == 7'h00
	) else $error("reserved activation bits not zero");

	// Read data stand only in the cycle after the strobe
	a_read_one_cycle: assert property (
		!$past(rd_i) |-> rdata_o == 8'h00
	) else $error("read data outside its cycle");

	// Four-byte flag follows the base held one cycle earlier
	a_four_byte_window: assert property (
		base_valid_o |-> $past(base_addr_o[1:0]) == 2'h0 &&
		                 $past(base_addr_o) >= `PPC_BASE_MIN &&
		                 $past(base_addr_o) <= `PPC_BASE_MAX4
	) else $error("four-byte flag outside its window");

	// High base byte lands in the high half of the base
	a_base_high_pair: assert property (
		wr_i && addr_i == `PPC_OFF_BASE_HI |=> base_addr_o[15:8] == $past(wdata_i)
	) else $error("high base byte not stored");

	// Code 1 on a base without eight-byte alignment falls back
	a_epp_fallback: assert property (
		!$past(global_port_mode_override_i) && $past(st_r.mode) == `PPC_MC_EPP19 &&
		!epp_allowed_o |-> mode_o == ppc_pkg::PPC_MD_SPP && !epp_active_o
	) else $error("enhanced code not refused on four-byte base");

	// Code 5 with alignment is enhanced 1.7 plus standard
	a_epp17_code: assert property (
		!$past(global_port_mode_override_i) && $past(st_r.mode) == `PPC_MC_EPP17 && epp_allowed_o
		|-> mode_o == ppc_pkg::PPC_MD_EPP17 && epp_active_o && !ecp_active_o
	) else $error("enhanced 1.7 code misdecoded");

	// Code 0 is plain standard mode with no extra protocol
	a_spp_code: assert property (
		!$past(global_port_mode_override_i) && $past(st_r.mode) == `PPC_MC_SPP
		|-> mode_o == ppc_pkg::PPC_MD_SPP && !epp_active_o && !ecp_active_o
	) else $error("standard code misdecoded");

	// Code 6 is reserved and raises no protocol flag
	a_reserved_code: assert property (
		!$past(global_port_mode_override_i) && $past(st_r.mode) == `PPC_MC_RSVD
		|-> mode_o == ppc_pkg::PPC_MD_RSVD && !epp_active_o && !ecp_active_o
	) else $error("reserved code misdecoded");

	// Code 2 is extended capabilities alone
	a_ecp_alone_code: assert property (
		!$past(global_port_mode_override_i) && $past(st_r.mode) == `PPC_MC_ECP
		|-> mode_o == ppc_pkg::PPC_MD_ECP && ecp_active_o && !epp_active_o
	) else $error("extended code misdecoded");

	// Field governs whenever the override was clear
	a_field_governs: assert property (
		!$past(global_port_mode_override_i) |-> mode_from_field_o
	) else $error("mode field ignored without override");

	// Upper interrupt select bits are not stored
	a_irq_reserved: assert property (
		rd_i && addr_i == `PPC_OFF_IRQ |=> rdata_o[7:4] == 4'h0
	) else $error("reserved interrupt bits not zero");

	// Upper DMA select bits are not stored
	a_dma_reserved: assert property (
		rd_i && addr_i == `PPC_OFF_DMA |=> rdata_o[7:3] == 5'h00
	) else $error("reserved DMA bits not zero");

	// Main scenarios
	c_write_read: cover property (
		wr_i && addr_i == `PPC_OFF_MODE ##1 rd_i && addr_i == `PPC_OFF_MODE
	);
	c_ecp_epp17: cover property (mode_o == ppc_pkg::PPC_MD_ECP_EPP17);
	c_dma_off: cover property (!dma_req_en_o ##1 dma_req_en_o);
	c_override: cover property (mode_o == ppc_pkg::PPC_MD_EXTERN);
	c_four_byte: cover property (base_valid_o && !epp_allowed_o);

endmodule
`default_nettype wire

// *** dv/tb_top.sv ***
// Self-checking bench for the parallel port configuration bank.
// Assumes the bank answers reads one cycle later and never stalls.
`timescale 1ns/1ps
`default_nettype none
`include "ppc_map.svh"

module tb_top;

	// ------------------------------------------------------------
	// Signals and counters
	// ------------------------------------------------------------
	logic                   clk_i;
	logic                   rst_n_i;
	logic [7:0]             addr_i;
	logic [7:0]             wdata_i;
	logic                   wr_i;
	logic                   rd_i;
	logic                   ovr_i;
	logic [7:0]             rdata_o;
	logic                   dev_active_o;
	logic [15:0]            base_addr_o;
	logic                   base_valid_o;
	logic                   epp_allowed_o;
	logic [3:0]             irq_sel_o;
	logic                   dma_req_en_o;
	logic [1:0]             dma_chan_o;
	logic [3:0]             fifo_thresh_o;
	ppc_pkg::ppc_mode_t     mode_o;
	logic                   mode_from_field_o;
	logic                   epp_active_o;
	logic                   ecp_active_o;
	int                     n_mismatch;
	int                     cmp_count;
	ppc_pkg::ppc_mode_t     em;
	logic [7:0]             offs [6] = '{`PPC_OFF_ACTIVATE, `PPC_OFF_BASE_HI, `PPC_OFF_BASE_LO,
		`PPC_OFF_IRQ, `PPC_OFF_DMA, `PPC_OFF_MODE};
	logic [7:0]             rstv [6] = '{8'h01, 8'h03, 8'h78, 8'h07, 8'h04, 8'h3f};
	logic [7:0]             mask [6] = '{8'h01, 8'hff, 8'hff, 8'h0f, 8'h07, 8'h7f};
	logic [15:0]            bases [8] = '{16'h0378, 16'h037c, 16'h0100, 16'h0ff8, 16'h0ffc,
		16'h00f8, 16'h1000, 16'h0379};
	logic [1:0]             bexp [8] = '{2'b11, 2'b10, 2'b11, 2'b11, 2'b10, 2'b00, 2'b00, 2'b00};

	ppc_bank dut (
		.clk_i                       (clk_i),
		.rst_n_i                     (rst_n_i),
		.addr_i                      (addr_i),
		.wdata_i                     (wdata_i),
		.wr_i                        (wr_i),
		.rd_i                        (rd_i),
		.global_port_mode_override_i (ovr_i),
		.rdata_o                     (rdata_o),
		.dev_active_o                (dev_active_o),
		.base_addr_o                 (base_addr_o),
		.base_valid_o                (base_valid_o),
		.epp_allowed_o               (epp_allowed_o),
		.irq_sel_o                   (irq_sel_o),
		.dma_req_en_o                (dma_req_en_o),
		.dma_chan_o                  (dma_chan_o),
		.fifo_thresh_o               (fifo_thresh_o),
		.mode_o                      (mode_o),
		.mode_from_field_o           (mode_from_field_o),
		.epp_active_o                (epp_active_o),
		.ecp_active_o                (ecp_active_o)
	);

	// ------------------------------------------------------------
	// Clock, verdict and watchdog
	// ------------------------------------------------------------
	initial begin
		clk_i = 1'b0;
		forever #2 clk_i = ~clk_i;
	end

	task automatic test_done();
		if (n_mismatch == 0 && cmp_count > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask

	// Whole run is a few hundred cycles, so this only trips on a hang
	initial begin
		repeat (20000) @(posedge clk_i);
		n_mismatch++;
		test_done();
	end

	// ------------------------------------------------------------
	// Compare and bus tasks
	// ------------------------------------------------------------
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp, input string what);
		cmp_count++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("CHECK FAILED at %0t: %s seen %h expected %h", $time, what, seen, exp);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_i);
		wr_i    <= 1'b1;
		addr_i  <= a;
		wdata_i <= d;
		@(posedge clk_i);
		wr_i    <= 1'b0;
	endtask

	// Read data stand only in the cycle after the strobe
	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		@(posedge clk_i);
		rd_i   <= 1'b1;
		addr_i <= a;
		@(posedge clk_i);
		rd_i   <= 1'b0;
		#1;
		chk(16'(rdata_o), 16'(exp), "read data");
	endtask

	// Decoded outputs trail the register by one edge
	task automatic settle();
		repeat (2) @(posedge clk_i);
		#1;
	endtask

	function automatic ppc_pkg::ppc_mode_t exp_mode(input logic [2:0] c, input logic ok8,
		input logic ovr);
		if (ovr) return ppc_pkg::PPC_MD_EXTERN;
		case (c)
			3'h0: return ppc_pkg::PPC_MD_SPP;
			3'h1: return ok8 ? ppc_pkg::PPC_MD_EPP19 : ppc_pkg::PPC_MD_SPP;
			3'h2: return ppc_pkg::PPC_MD_ECP;
			3'h3: return ok8 ? ppc_pkg::PPC_MD_ECP_EPP19 : ppc_pkg::PPC_MD_ECP;
			3'h4: return ppc_pkg::PPC_MD_PRINTER;
			3'h5: return ok8 ? ppc_pkg::PPC_MD_EPP17 : ppc_pkg::PPC_MD_SPP;
			3'h6: return ppc_pkg::PPC_MD_RSVD;
			default: return ok8 ? ppc_pkg::PPC_MD_ECP_EPP17 : ppc_pkg::PPC_MD_ECP;
		endcase
	endfunction

	// Mode write plus every decoded output that follows from it
	task automatic mode_case(input logic [2:0] c, input logic ok8, input logic ovr);
		wr(`PPC_OFF_MODE, {1'b0, 4'(c + 3'h2), c});
		ovr_i <= ovr;
		settle();
		em = exp_mode(c, ok8, ovr);
		chk(16'(mode_o), 16'(em), "mode");
		chk(16'(mode_from_field_o), 16'(!ovr), "mode from field");
		chk(16'(epp_active_o), 16'(em inside {ppc_pkg::PPC_MD_EPP19,
			ppc_pkg::PPC_MD_EPP17, ppc_pkg::PPC_MD_ECP_EPP19,
			ppc_pkg::PPC_MD_ECP_EPP17}), "enhanced flag");
		chk(16'(ecp_active_o), 16'(em inside {ppc_pkg::PPC_MD_ECP, ppc_pkg::PPC_MD_ECP_EPP19,
			ppc_pkg::PPC_MD_ECP_EPP17}), "extended flag");
		chk(16'(fifo_thresh_o), 16'(4'(c + 3'h2)), "fifo threshold");
	endtask

	// ------------------------------------------------------------
	// Test sequence
	// ------------------------------------------------------------
	initial begin
		n_mismatch = 0;
		cmp_count  = 0;
		rst_n_i    = 1'b0;
		addr_i     = 8'h00;
		wdata_i    = 8'h00;
		wr_i       = 1'b0;
		rd_i       = 1'b0;
		ovr_i      = 1'b0;
		repeat (15) @(posedge clk_i);
		#1;
		chk(16'(dev_active_o), 16'h0001, "active in reset");
		chk(base_addr_o, 16'h0378, "base in reset");
		chk(16'(irq_sel_o), 16'h0007, "irq in reset");
		chk(16'(dma_req_en_o), 16'h0000, "dma off in reset");
		@(posedge clk_i);
		rst_n_i <= 1'b1;
		settle();
		chk(16'(mode_o), 16'(ppc_pkg::PPC_MD_ECP_EPP17), "mode after reset");
		// Reset values, then reserved bits masked off
		for (int i = 0; i < 6; i++) begin
			rd(offs[i], rstv[i]);
			wr(offs[i], 8'hff);
			rd(offs[i], mask[i]);
		end
		// Unmapped offset and back-to-back write then read
		wr(8'h31, 8'h5a);
		rd(8'h31, 8'h00);
		@(posedge clk_i);
		wr_i    <= 1'b1;
		addr_i  <= `PPC_OFF_IRQ;
		wdata_i <= 8'hfa;
		@(posedge clk_i);
		wr_i    <= 1'b0;
		rd_i    <= 1'b1;
		@(posedge clk_i);
		rd_i    <= 1'b0;
		#1;
		chk(16'(rdata_o), 16'h000a, "back to back read");
		chk(16'(irq_sel_o), 16'h000a, "irq select");
		@(posedge clk_i);
		#1;
		chk(16'(rdata_o), 16'h0000, "read data released");
		// Activation both ways
		wr(`PPC_OFF_ACTIVATE, 8'hfe);
		settle();
		chk(16'(dev_active_o), 16'h0000, "inactive");
		wr(`PPC_OFF_ACTIVATE, 8'h01);
		settle();
		chk(16'(dev_active_o), 16'h0001, "active");
		// Every DMA code
		for (int c = 0; c < 8; c++) begin
			wr(`PPC_OFF_DMA, 8'(c));
			settle();
			chk(16'(dma_req_en_o), 16'(c < 4), "dma enable");
			chk(16'(dma_chan_o), 16'(c % 4), "dma channel");
		end
		// Base window and alignment edges
		for (int i = 0; i < 8; i++) begin
			wr(`PPC_OFF_BASE_HI, bases[i][15:8]);
			wr(`PPC_OFF_BASE_LO, bases[i][7:0]);
			settle();
			chk(base_addr_o, bases[i], "base address");
			chk(16'(base_valid_o), 16'(bexp[i][1]), "base valid");
			chk(16'(epp_allowed_o), 16'(bexp[i][0]), "enhanced allowed");
		end
		// Every mode code on an 8-aligned base, then on a 4-aligned one
		wr(`PPC_OFF_BASE_HI, 8'h03);
		wr(`PPC_OFF_BASE_LO, 8'h78);
		for (int c = 0; c < 8; c++) mode_case(3'(c), 1'b1, 1'b0);
		wr(`PPC_OFF_BASE_LO, 8'h7c);
		for (int c = 0; c < 8; c++) mode_case(3'(c), 1'b0, 1'b0);
		// Global override wins over the field, release restores it
		mode_case(3'h3, 1'b0, 1'b1);
		mode_case(3'h3, 1'b0, 1'b0);
		test_done();
	end

endmodule
`default_nettype wire
